//--- uec_pkg.sv
package uec_pkg;
  // Register indices on the serial control port
  localparam logic [3:0] ADDR_FAR_ERR = 4'h4;
  localparam logic [3:0] ADDR_NEAR_ERR = 4'h5;
  localparam logic [3:0] ADDR_LOOP = 4'h6;
  localparam logic [3:0] ADDR_CFG = 4'h7;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] LOOP_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Loopback control field positions
  localparam int LB_U_B1 = 7;
  localparam int LB_U_B2 = 6;
  localparam int LB_U_2BD = 5;
  localparam int LB_U_TR = 4;
  localparam int LB_P_B1 = 3;
  localparam int LB_P_B2 = 2;
  localparam int LB_P_2BD = 1;
  localparam int LB_P_TR = 0;
  // Port configuration field positions
  localparam int CFG_ALT15 = 7;
  localparam int CFG_GP_OUTPUT_TWO = 6;
  localparam int CFG_GP_OUTPUT_ONE = 5;
  localparam int CFG_INV = 4;
  localparam int CFG_FREE = 3;
  localparam int CFG_SPEED = 2;
  localparam int CFG_MSINV = 1;
  localparam int CFG_ORD8 = 0;
  // Clock rates in Hz and derived generator constants
  localparam longint CORE_HZ = 40000000;
  localparam longint BCLK_SLOW_HZ = 2560000;
  localparam longint BCLK_FAST_HZ = 2048000;
  localparam longint FRAME_HZ = 8000;
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC_SLOW = NCO_W'((BCLK_SLOW_HZ << NCO_W) / CORE_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_FAST = NCO_W'((BCLK_FAST_HZ << NCO_W) / CORE_HZ);
  localparam logic [8:0] BITS_SLOW = 9'(BCLK_SLOW_HZ / FRAME_HZ);
  localparam logic [8:0] BITS_FAST = 9'(BCLK_FAST_HZ / FRAME_HZ);
  // Serial control frame: 8 command bits then 8 data bits
  localparam logic [4:0] SCP_CMD_BITS = 5'd8;
  localparam logic [4:0] SCP_FRAME_BITS = 5'd16;
  localparam int SCP_RD_BIT = 7;

  typedef enum logic [1:0] {
    SCP_IDLE = 2'b00,
    SCP_CMD = 2'b01,
    SCP_DATA = 2'b11,
    SCP_DONE = 2'b10
  } uec_scp_e;

  typedef enum logic [1:0] {
    ORD_TEN = 2'b00,
    ORD_EIGHT = 2'b01,
    ORD_TSA = 2'b11,
    ORD_GCI = 2'b10
  } uec_order_e;

  typedef struct packed {
    logic sf_sync;
    logic linkup;
    logic sf_end;
    logic framer_sf_end;
    logic febe;
    logic crc_err;
  } uec_rx_ev_s;

  typedef struct packed {
    logic u_b1;
    logic u_b2;
    logic u_d;
    logic u_transp;
    logic p_b1;
    logic p_b2;
    logic p_d;
    logic p_transp;
  } uec_loop_s;
endpackage

//--- uec_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Error counters ignore both resets; a port write loads any value.
// - Far-end counter steps at superframe end on febe, only when synced and linked.
// - Far-end counter wraps past ff when wrap enabled, else sticks at ff.
// - Near-end counts crc mismatch, and per framer superframe when linked but unsynced.
// - A detected crc error counts at the end of that superframe.
// - Near-end counter uses the same wrap or saturate choice.
// - With overlay selected, these four addresses reach the overlay registers instead.
// - Loopback control clears on either reset and on return-to-normal.
// - Line-side loopback bits cannot become set in automatic eoc mode.
// - Line-side bits loop B1, B2 or 2B+D; transparent covers all looped.
// - Port 2B+D loopback overrides the separate port B1 and B2 bits.
// - Port loopbacks work in every port mode; transparent covers all looped.
// - Port config clears on resets; bit 7 selects alternate register fifteen.
// - Output two drives its pin, reads input two; disable forces high; D2 sets.
// - Output one drives its pin, reads input one; D1 command sets it.
// - Invert bit flips every transmitted and received data bit.
// - Master clocks run free, or start on sync and stop on deactivation.
// - Speed bit picks 2.56 or 2.048 MHz; also reference rate as slave.
// - Master/slave invert bit flips the sense of the master/slave pin.
// - Eight-bit order sends B bytes then D bits; ten-bit interleaves; swap applies.
// - Timeslot assignment overrides the ordering bit.
// - GCI electrical mode carries only 2B+D in programmed GCI slots.
module uec_regs (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic return_normal,
  input wire logic scp_clk,
  input wire logic scp_sel_n,
  input wire logic scp_din,
  output logic scp_dout,
  output logic scp_dout_en_n,
  input wire uec_pkg::uec_rx_ev_s rx_ev,
  input wire logic wrap_enable,
  input wire logic overlay_select,
  input wire logic eoc_auto,
  input wire logic timeslot_en,
  input wire logic gci_electrical,
  input wire logic [2:0] gci_slot,
  input wire logic channel_swap,
  input wire logic host_mode_select_pin,
  input wire logic ms_pin,
  input wire logic nt_mode,
  input wire logic port_stop,
  input wire logic disable_command,
  input wire logic line_side_d1_command,
  input wire logic line_side_d2_command,
  input wire logic network_side_d1_command,
  input wire logic network_side_d2_command,
  input wire logic gp_input_one,
  input wire logic gp_input_two,
  output logic gp_output_one,
  output logic gp_output_two,
  input wire logic [7:0] ovl_rdata,
  output logic [3:0] ovl_addr,
  output logic [7:0] ovl_wdata,
  output logic ovl_wr,
  output uec_pkg::uec_loop_s loop,
  output logic alt15_select,
  output logic port_master,
  output uec_pkg::uec_order_e order_mode,
  output logic b_swap,
  output logic [2:0] gci_slot_out,
  output logic port_bit_clock,
  output logic port_frame_syncs,
  output logic reference_clock_out,
  input wire logic tx_bit,
  output logic port_data_out,
  input wire logic port_data_in,
  output logic rx_bit
);
  logic [7:0] sync1_r, sync2_r;
  logic sclk_d_r;
  uec_pkg::uec_scp_e scp_st_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] sh_r, rd_sh_r, cmd_r;
  logic wr_pulse_r;
  logic [3:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] far_r, near_r, loop_r, cfg_r;
  logic gp_output_one_r, gp_output_two_r;
  logic running_r, sync_d_r;
  logic [uec_pkg::NCO_W-1:0] acc_r;
  logic [8:0] fbit_r;
  logic bclk_d_r;
  logic sclk_s, sel_n_s, sdin_s, gci_full, in1_s, in2_s, ms_s, din_s;
  logic sclk_rise, sclk_fall, in_map, ovl_hit, clk_run;
  logic wr_far, wr_near, far_inc, near_inc;
  logic [7:0] rd_data;

  function automatic logic [7:0] count_step(input logic [7:0] cur, input logic wrap);
    count_step = (!wrap && cur == uec_pkg::CNT_MAX) ? cur : cur + 8'h01;
  endfunction

  // Two-flop synchronisers for every pin from outside the core clock
  always_ff @(posedge core_clk) begin
    sync1_r <= {scp_clk, scp_sel_n, scp_din, host_mode_select_pin,
                gp_input_one, gp_input_two, ms_pin, port_data_in};
    sync2_r <= sync1_r;
    sclk_d_r <= sync2_r[7];
  end

  assign {sclk_s, sel_n_s, sdin_s} = sync2_r[7:5];
  assign gci_full = ~sync2_r[4]; // Low on the mode pin means full GCI
  assign {in1_s, in2_s, ms_s, din_s} = sync2_r[3:0];
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // Serial control port: command byte, then data byte, MSB first
  always_ff @(posedge core_clk) begin
    wr_pulse_r <= 1'b0;
    if (!reset_n || sel_n_s) begin
      scp_st_r <= uec_pkg::SCP_IDLE;
      bit_cnt_r <= 5'd0;
    end else begin
      case (scp_st_r)
        uec_pkg::SCP_IDLE: scp_st_r <= uec_pkg::SCP_CMD;
        uec_pkg::SCP_CMD: begin
          if (sclk_rise) begin
            sh_r <= {sh_r[6:0], sdin_s};
            bit_cnt_r <= bit_cnt_r + 5'd1;
            if (bit_cnt_r == uec_pkg::SCP_CMD_BITS - 5'd1) begin
              cmd_r <= {sh_r[6:0], sdin_s};
              scp_st_r <= uec_pkg::SCP_DATA;
            end
          end
        end
        uec_pkg::SCP_DATA: begin
          if (sclk_rise) begin
            sh_r <= {sh_r[6:0], sdin_s};
            bit_cnt_r <= bit_cnt_r + 5'd1;
            if (bit_cnt_r == uec_pkg::SCP_FRAME_BITS - 5'd1) begin
              wr_pulse_r <= ~cmd_r[uec_pkg::SCP_RD_BIT];
              wr_addr_r <= cmd_r[3:0];
              wr_data_r <= {sh_r[6:0], sdin_s};
              scp_st_r <= uec_pkg::SCP_DONE;
            end
          end
        end
        uec_pkg::SCP_DONE: scp_st_r <= uec_pkg::SCP_DONE;
        default: scp_st_r <= uec_pkg::SCP_IDLE;
      endcase
    end
  end

  // Read data shifts out on falling edges; the pin is driven only for reads
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_sh_r <= 8'h00;
      scp_dout_en_n <= 1'b1;
    end else if (scp_st_r == uec_pkg::SCP_CMD && sclk_rise &&
                 bit_cnt_r == uec_pkg::SCP_CMD_BITS - 5'd1) begin
      rd_sh_r <= rd_data;
      scp_dout_en_n <= ~sh_r[uec_pkg::SCP_RD_BIT - 1];
    end else if (scp_st_r == uec_pkg::SCP_DATA && sclk_fall) begin
      rd_sh_r <= {rd_sh_r[6:0], 1'b0};
    end else if (scp_st_r != uec_pkg::SCP_DATA) begin
      scp_dout_en_n <= 1'b1;
    end
  end
  assign scp_dout = rd_sh_r[7];

  // overlay address steering
  // Command bits 3:2 sit in sh_r[2:1] one bit before the command byte completes
  assign in_map = sh_r[2:1] == 2'b01;
  assign ovl_hit = overlay_select && wr_addr_r[3:2] == 2'b01;

  // Read mux; the address is the low nibble of the command just shifted in
  always_comb begin
    rd_data = uec_pkg::RD_UNMAPPED;
    if (overlay_select && in_map) begin
      rd_data = ovl_rdata;
    end else begin
      case ({sh_r[2:0], sdin_s})
        uec_pkg::ADDR_FAR_ERR: rd_data = far_r;
        uec_pkg::ADDR_NEAR_ERR: rd_data = near_r;
        uec_pkg::ADDR_LOOP: rd_data = loop_r;
        uec_pkg::ADDR_CFG: rd_data = {cfg_r[7], gci_full & in2_s, gci_full & in1_s,
                                      cfg_r[4:0]};
        default: rd_data = uec_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // Overlay write port, registered
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ovl_wr <= 1'b0;
      ovl_addr <= 4'h0;
      ovl_wdata <= 8'h00;
    end else begin
      ovl_wr <= wr_pulse_r && ovl_hit;
      ovl_addr <= wr_addr_r;
      ovl_wdata <= wr_data_r;
    end
  end

  assign wr_far = wr_pulse_r && !ovl_hit && wr_addr_r == uec_pkg::ADDR_FAR_ERR;
  assign wr_near = wr_pulse_r && !ovl_hit && wr_addr_r == uec_pkg::ADDR_NEAR_ERR;
  assign far_inc = rx_ev.sf_end && rx_ev.febe && rx_ev.sf_sync && rx_ev.linkup;
  // near-end events from deframer or framer timing
  assign near_inc = (rx_ev.sf_end && rx_ev.crc_err && rx_ev.sf_sync && rx_ev.linkup) ||
                    (rx_ev.framer_sf_end && rx_ev.linkup && !rx_ev.sf_sync);

  // Counters carry no reset so the error history survives any reset
  always_ff @(posedge core_clk) begin
    if (wr_far) begin
      far_r <= wr_data_r;
    end else if (far_inc) begin
      far_r <= count_step(far_r, wrap_enable);
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_near) begin
      near_r <= wr_data_r;
    end else if (near_inc) begin
      near_r <= count_step(near_r, wrap_enable);
    end
  end

  // Loopback control
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_reset || return_normal) begin
      loop_r <= uec_pkg::LOOP_RST;
    end else if (wr_pulse_r && !ovl_hit && wr_addr_r == uec_pkg::ADDR_LOOP) begin
      // in eoc_auto mode line-side bits may clear but not set
      loop_r <= {wr_data_r[7:4] & (eoc_auto ? loop_r[7:4] : 4'hf), wr_data_r[3:0]};
    end
  end

  assign loop.u_b1 = loop_r[uec_pkg::LB_U_B1] | loop_r[uec_pkg::LB_U_2BD];
  assign loop.u_b2 = loop_r[uec_pkg::LB_U_B2] | loop_r[uec_pkg::LB_U_2BD];
  assign loop.u_d = loop_r[uec_pkg::LB_U_2BD];
  assign loop.u_transp = loop_r[uec_pkg::LB_U_TR];
  // port loop decode, independent of port mode
  assign loop.p_b1 = loop_r[uec_pkg::LB_P_2BD] | loop_r[uec_pkg::LB_P_B1];
  assign loop.p_b2 = loop_r[uec_pkg::LB_P_2BD] | loop_r[uec_pkg::LB_P_B2];
  assign loop.p_d = loop_r[uec_pkg::LB_P_2BD];
  assign loop.p_transp = loop_r[uec_pkg::LB_P_TR];

  // Port configuration; output bits are write-only and kept apart
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_reset) begin
      cfg_r <= uec_pkg::CFG_RST;
    end else if (wr_pulse_r && !ovl_hit && wr_addr_r == uec_pkg::ADDR_CFG) begin
      cfg_r <= wr_data_r;
    end
  end

  // General purpose outputs: a command set wins over a write
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_reset) begin
      gp_output_one_r <= 1'b0;
      gp_output_two_r <= 1'b0;
    end else begin
      if (wr_pulse_r && !ovl_hit && wr_addr_r == uec_pkg::ADDR_CFG) begin
        gp_output_one_r <= wr_data_r[uec_pkg::CFG_GP_OUTPUT_ONE];
        gp_output_two_r <= wr_data_r[uec_pkg::CFG_GP_OUTPUT_TWO];
      end
      if (nt_mode ? network_side_d1_command : line_side_d1_command) begin
        gp_output_one_r <= 1'b1;
      end
      if (nt_mode ? network_side_d2_command : line_side_d2_command) begin
        gp_output_two_r <= 1'b1;
      end
    end
  end

  // pins driven in full GCI; disable forces output two high
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gp_output_one <= 1'b0;
      gp_output_two <= 1'b0;
    end else begin
      gp_output_one <= gci_full & gp_output_one_r;
      gp_output_two <= gci_full & (gp_output_two_r | disable_command);
    end
  end

  assign alt15_select = cfg_r[uec_pkg::CFG_ALT15];

  // Mode outputs
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_master <= 1'b0;
      order_mode <= uec_pkg::ORD_TEN;
      b_swap <= 1'b0;
      gci_slot_out <= 3'd0;
    end else begin
      // pin sense flipped by invert bit
      port_master <= ms_s ^ cfg_r[uec_pkg::CFG_MSINV];
      if (gci_electrical) begin
        order_mode <= uec_pkg::ORD_GCI;
      end else if (timeslot_en) begin
        order_mode <= uec_pkg::ORD_TSA;
      end else if (cfg_r[uec_pkg::CFG_ORD8]) begin
        order_mode <= uec_pkg::ORD_EIGHT;
      end else begin
        order_mode <= uec_pkg::ORD_TEN;
      end
      b_swap <= channel_swap;
      gci_slot_out <= gci_slot;
    end
  end

  // free-run gate: start on sync rising, stop on deactivation
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_reset) begin
      running_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= rx_ev.sf_sync;
      if (port_stop) begin
        running_r <= 1'b0;
      end else if (rx_ev.sf_sync && !sync_d_r) begin
        running_r <= 1'b1;
      end
    end
  end
  assign clk_run = port_master && (!cfg_r[uec_pkg::CFG_FREE] || running_r);

  // fractional generator; 40 MHz is no multiple of either rate, so edges jitter
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_r + (cfg_r[uec_pkg::CFG_SPEED] ? uec_pkg::NCO_INC_FAST :
                        uec_pkg::NCO_INC_SLOW);
    end
  end

  // Bit clock and frame sync; frame sync marks the first bit of each 8 kHz frame
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bclk_d_r <= 1'b0;
      fbit_r <= 9'd0;
      port_bit_clock <= 1'b0;
      port_frame_syncs <= 1'b0;
      reference_clock_out <= 1'b0;
    end else begin
      bclk_d_r <= acc_r[uec_pkg::NCO_W-1];
      port_bit_clock <= clk_run & acc_r[uec_pkg::NCO_W-1];
      // reference rate in network-side slave mode
      reference_clock_out <= nt_mode & ~port_master & acc_r[uec_pkg::NCO_W-1];
      if (!clk_run) begin
        fbit_r <= 9'd0;
        port_frame_syncs <= 1'b0;
      end else if (acc_r[uec_pkg::NCO_W-1] && !bclk_d_r) begin
        port_frame_syncs <= fbit_r == 9'd0;
        fbit_r <= (fbit_r == (cfg_r[uec_pkg::CFG_SPEED] ? uec_pkg::BITS_FAST :
                              uec_pkg::BITS_SLOW) - 9'd1) ? 9'd0 : fbit_r + 9'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_data_out <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      port_data_out <= tx_bit ^ cfg_r[uec_pkg::CFG_INV];
      rx_bit <= din_s ^ cfg_r[uec_pkg::CFG_INV];
    end
  end

  // Far counter is unknown until first loaded, so hold checks wait for a write
  logic far_seen_r;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      far_seen_r <= 1'b0;
    end else if (wr_far) begin
      far_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_far_count_up: assert property (far_inc && !wr_far && far_r != 8'hff |=>
    far_r == $past(far_r) + 8'h01) else $error("far count did not step");
  a_far_sat_hold: assert property (far_inc && !wr_far && !wrap_enable && far_r == 8'hff
    |=> far_r == 8'hff) else $error("far count left saturation");
  a_far_wrap_zero: assert property (far_inc && !wr_far && wrap_enable && far_r == 8'hff
    |=> far_r == 8'h00) else $error("far count did not wrap");
  a_far_gate_hold: assert property (far_seen_r && !(rx_ev.sf_sync && rx_ev.linkup) && !wr_far
    |=> far_r == $past(far_r)) else $error("far count moved unsynced");
  a_near_count_up: assert property (near_inc && !wr_near && near_r != 8'hff |=>
    near_r == $past(near_r) + 8'h01) else $error("near count did not step");
  a_write_wins: assert property (wr_far |=> far_r == $past(wr_data_r))
    else $error("write lost to increment");
  a_loop_return: assert property (return_normal |=> loop_r == 8'h00)
    else $error("loopback not cleared");
  a_eoc_no_set: assert property (eoc_auto |=> (loop_r[7:4] & ~$past(loop_r[7:4])) == 4'h0)
    else $error("line loop set in eoc mode");
  a_tx_invert: assert property (cfg_r[uec_pkg::CFG_INV] |=> port_data_out == !$past(tx_bit))
    else $error("data not inverted");
  a_disable_high: assert property (gci_full && disable_command |=> gp_output_two)
    else $error("output two not forced");

  c_far_wrap: cover property (far_inc && wrap_enable && far_r == 8'hff);
  c_near_framer: cover property (rx_ev.framer_sf_end && rx_ev.linkup && !rx_ev.sf_sync);
  c_ovl_write: cover property (ovl_wr);
  c_scp_read: cover property (!scp_dout_en_n ##1 scp_dout_en_n);
endmodule

//--- uec_mcu.sv
`timescale 1ns/1ps
// Microcontroller on the serial control port; link clock idles low between frames
module uec_mcu (
  input wire logic core_clk,
  input wire logic scp_dout,
  output logic scp_clk,
  output logic scp_sel_n,
  output logic scp_din
);
  initial begin
    scp_clk = 1'b0;
    scp_sel_n = 1'b1;
    scp_din = 1'b0;
  end

  // Half link period, 100 ns
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  // Command then data, MSB first; reply bits sampled late in the high phases of clocks 8 to 15
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    scp_sel_n = 1'b0;
    half();
    for (int i = 0; i < 16; i++) begin
      scp_din = sh[15-i];
      half();
      scp_clk = 1'b1;
      half();
      if (i >= 7 && i < 15) rd = {rd[6:0], scp_dout};
      scp_clk = 1'b0;
    end
    half();
    scp_sel_n = 1'b1;
    // Released line flips so a stale bit never looks valid
    scp_din = ~scp_din;
    half();
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
// Register traffic over the serial control port with expected values
module testbench;
  logic core_clk, reset_n, soft_reset, return_normal, scp_clk, scp_sel_n, scp_din;
  logic scp_dout, den_n, wrap_enable, overlay_select, eoc_auto, timeslot_en, gci_el;
  logic swap, host_pin, ms_pin, port_stop, dis, d1, d2, gp_in1, gp_in2, gp_gp_output_one;
  logic gp_gp_output_two, alt15, master, b_swap, bclk, tx_bit, pd_out, pd_in, rx_bit;
  logic [7:0] ovl_rdata, ovl_wdata, rd;
  logic [3:0] ovl_addr;
  logic [2:0] gslot, gslot_o;
  logic ovl_wr_w;
  int ovl_n = 0;
  uec_pkg::uec_rx_ev_s rx_ev;
  uec_pkg::uec_loop_s loop;
  uec_pkg::uec_order_e order_mode;
  int bad_count = 0;
  int n_checks = 0;
  localparam logic [3:0] A_FAR = uec_pkg::ADDR_FAR_ERR;
  localparam logic [3:0] A_NEAR = uec_pkg::ADDR_NEAR_ERR;
  localparam logic [3:0] A_LOOP = uec_pkg::ADDR_LOOP;
  localparam logic [3:0] A_CFG = uec_pkg::ADDR_CFG;
  localparam int F_SLOW = int'(uec_pkg::BCLK_SLOW_HZ * 1000 / uec_pkg::CORE_HZ);
  localparam int F_FAST = int'(uec_pkg::BCLK_FAST_HZ * 1000 / uec_pkg::CORE_HZ);

  uec_regs dut (
    .core_clk(core_clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .return_normal(return_normal), .scp_clk(scp_clk), .scp_sel_n(scp_sel_n),
    .scp_din(scp_din), .scp_dout(scp_dout), .scp_dout_en_n(den_n), .rx_ev(rx_ev),
    .wrap_enable(wrap_enable), .overlay_select(overlay_select), .eoc_auto(eoc_auto),
    .timeslot_en(timeslot_en), .gci_electrical(gci_el), .gci_slot(gslot),
    .channel_swap(swap), .host_mode_select_pin(host_pin), .ms_pin(ms_pin),
    .nt_mode(1'b0), .port_stop(port_stop), .disable_command(dis),
    .line_side_d1_command(d1), .line_side_d2_command(d2),
    .network_side_d1_command(1'b0), .network_side_d2_command(1'b0),
    .gp_input_one(gp_in1), .gp_input_two(gp_in2), .gp_output_one(gp_gp_output_one),
    .gp_output_two(gp_gp_output_two), .ovl_rdata(ovl_rdata), .ovl_addr(ovl_addr),
    .ovl_wdata(ovl_wdata), .ovl_wr(ovl_wr_w), .loop(loop), .alt15_select(alt15),
    .port_master(master), .order_mode(order_mode), .b_swap(b_swap), .gci_slot_out(gslot_o),
    .port_bit_clock(bclk), .port_frame_syncs(), .reference_clock_out(),
    .tx_bit(tx_bit), .port_data_out(pd_out), .port_data_in(pd_in), .rx_bit(rx_bit)
  );

  uec_mcu mcu (
    .core_clk(core_clk), .scp_dout(scp_dout), .scp_clk(scp_clk),
    .scp_sel_n(scp_sel_n), .scp_din(scp_din)
  );

  // Overlay write strobes are one cycle wide, so count them as they pass
  always @(posedge core_clk) begin
    if (ovl_wr_w === 1'b1) ovl_n++;
  end

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    mcu.xfer({4'h0, a}, d, rd);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string s);
    mcu.xfer({4'h8, a}, 8'h00, rd);
    chk(rd, e, s);
  endtask

  // One-cycle superframe pulses; sync and linkup stay as levels afterwards
  task automatic ev(input logic [5:0] e, input int n);
    repeat (n) begin
      rx_ev = uec_pkg::uec_rx_ev_s'(e);
      w(1);
      rx_ev = uec_pkg::uec_rx_ev_s'(e & 6'h30);
      w(1);
    end
  endtask

  // Bit clock rising edges in 1000 core cycles; one edge of slack for NCO jitter
  task automatic bc(input int e, input string s);
    int n;
    logic p;
    n = 0;
    p = bclk;
    repeat (1000) begin
      w(1);
      if (bclk && !p) n++;
      p = bclk;
    end
    n_checks++;
    if (n < e - 1 || n > e + 1) begin
      bad_count++;
      $display("MISMATCH t=%0t %s edges %0d exp %0d", $time, s, n, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog, several times the expected run length
  initial begin
    #1000000;
    bad_count++;
    $display("MISMATCH t=%0t watchdog", $time);
    give_verdict();
  end

  // Main sequence; counters hold X until first written
  initial begin
    {reset_n, soft_reset, return_normal, wrap_enable, overlay_select, eoc_auto,
     timeslot_en, gci_el, swap, ms_pin, port_stop, dis, d1, d2, gp_in1, gp_in2,
     tx_bit, pd_in, rx_ev, ovl_rdata, gslot} = '0;
    host_pin = 1'b1;
    w(12);
    reset_n = 1'b1;
    w(3);
    wr(A_FAR, 8'hfd);
    wr(A_NEAR, 8'h7e);
    ev(6'h1a, 1);
    rdc(A_FAR, 8'hfd, "far unsynced");
    ev(6'h3a, 1);
    rdc(A_FAR, 8'hfe, "far step");
    ev(6'h3a, 3);
    rdc(A_FAR, 8'hff, "far sat");
    wrap_enable = 1'b1;
    ev(6'h3a, 1);
    rdc(A_FAR, 8'h00, "far wrap");
    ev(6'h39, 1);
    ev(6'h14, 1);
    rdc(A_NEAR, 8'h80, "near crc");
    wr(A_NEAR, 8'hff);
    ev(6'h39, 1);
    rdc(A_NEAR, 8'h00, "near wrap");
    wrap_enable = 1'b0;
    wr(A_NEAR, 8'hfe);
    ev(6'h14, 3);
    rdc(A_NEAR, 8'hff, "near sat");
    // Loopback register
    wr(A_LOOP, 8'h02);
    chk({5'h00, loop.p_b1, loop.p_b2, loop.p_d}, 8'h07, "port 2bd");
    eoc_auto = 1'b1;
    wr(A_LOOP, 8'hff);
    rdc(A_LOOP, 8'h0f, "eoc lock");
    eoc_auto = 1'b0;
    wr(A_LOOP, 8'hf1);
    chk(loop, 8'hf1, "line loop");
    return_normal = 1'b1;
    w(1);
    return_normal = 1'b0;
    rdc(A_LOOP, 8'h00, "normal");
    wr(A_LOOP, 8'h5a);
    soft_reset = 1'b1;
    w(1);
    soft_reset = 1'b0;
    rdc(A_LOOP, 8'h00, "soft loop");
    rdc(A_NEAR, 8'hff, "soft near");
    // Port configuration across a hard reset
    wr(A_CFG, 8'h80);
    chk({7'h00, alt15}, 8'h01, "alt15");
    wr(A_FAR, 8'h42);
    reset_n = 1'b0;
    w(3);
    reset_n = 1'b1;
    w(3);
    rdc(A_CFG, 8'h00, "cfg reset");
    rdc(A_FAR, 8'h42, "far kept");
    // Data port polarity, master sense and ordering
    ms_pin = 1'b1;
    tx_bit = 1'b1;
    wr(A_CFG, 8'h11);
    chk(8'(order_mode), 8'(uec_pkg::ORD_EIGHT), "ord8");
    chk({5'h00, master, pd_out, rx_bit}, 8'h05, "inv on");
    pd_in = 1'b1;
    wr(A_CFG, 8'h02);
    chk(8'(order_mode), 8'(uec_pkg::ORD_TEN), "ord10");
    chk({5'h00, master, pd_out, rx_bit}, 8'h03, "inv off");
    timeslot_en = 1'b1;
    w(4);
    chk(8'(order_mode), 8'(uec_pkg::ORD_TSA), "tsa");
    timeslot_en = 1'b0;
    gci_el = 1'b1;
    swap = 1'b1;
    gslot = 3'h5;
    w(4);
    chk(8'(order_mode), 8'(uec_pkg::ORD_GCI), "gci");
    chk({5'h00, gslot_o}, 8'h05, "gci slot");
    chk({7'h00, b_swap}, 8'h01, "swap");
    gci_el = 1'b0;
    // Full GCI general-purpose pins
    host_pin = 1'b0;
    gp_in2 = 1'b1;
    wr(A_CFG, 8'h60);
    chk({6'h00, gp_gp_output_two, gp_gp_output_one}, 8'h03, "gp out");
    rdc(A_CFG, 8'h40, "gp in");
    wr(A_CFG, 8'h00);
    dis = 1'b1;
    w(4);
    chk({6'h00, gp_gp_output_two, gp_gp_output_one}, 8'h02, "dis");
    dis = 1'b0;
    d1 = 1'b1;
    w(1);
    d1 = 1'b0;
    w(4);
    chk({6'h00, gp_gp_output_two, gp_gp_output_one}, 8'h01, "d1");
    d2 = 1'b1;
    w(1);
    d2 = 1'b0;
    w(4);
    chk({6'h00, gp_gp_output_two, gp_gp_output_one}, 8'h03, "d2");
    host_pin = 1'b1;
    // Unmapped place and overlay redirection
    rdc(4'h9, uec_pkg::RD_UNMAPPED, "unmapped");
    overlay_select = 1'b1;
    ovl_rdata = 8'hc3;
    rdc(A_LOOP, 8'hc3, "ovl rd");
    wr(A_LOOP, 8'h81);
    chk({ovl_addr, ovl_wdata[3:0]}, {A_LOOP, 4'h1}, "ovl wr");
    chk(8'(ovl_n), 8'h01, "ovl strobe");
    overlay_select = 1'b0;
    rdc(A_LOOP, 8'h00, "base kept");
    // Bit clock rate and free-run gating as port master
    wr(A_CFG, 8'h00);
    bc(F_SLOW, "slow");
    wr(A_CFG, 8'h04);
    bc(F_FAST, "fast");
    wr(A_CFG, 8'h0c);
    bc(0, "free idle");
    ev(6'h30, 1);
    bc(F_FAST, "free sync");
    port_stop = 1'b1;
    w(1);
    port_stop = 1'b0;
    bc(0, "free stop");
    give_verdict();
  end
endmodule
